// ---- hw/twi_sleep_wake.sv ----
// Sleep wakeup matcher for a two-wire slave: start detect, stretch, address/data match.
// Assumes clk_sys is an always-on detector clock; the peripheral clock is requested
// on periph_clk_req and reported running on periph_clk_ready from another domain.
`timescale 1ns/1ns
module twi_sleep_wake #(
  parameter int SETUP_CYC = twi_wake_pkg::STRETCH_SETUP_CYC
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  output logic [31:0] reg_rdata,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic sleep_active,
  input wire logic periph_clk_ready,
  output logic periph_clk_req,
  output logic wake_full,
  output logic irq
);

  // ****************************************************
  // Input synchronisers
  // ****************************************************
  logic scl_m_q, scl_s_q, scl_p_q, sda_m_q, sda_s_q, sda_p_q, rdy_m_q, rdy_s_q, slp_m_q, slp_s_q;

  // Pins and the foreign clock-ready level pass two flops before any use
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      {scl_m_q, scl_s_q, scl_p_q} <= 3'h7;
      {sda_m_q, sda_s_q, sda_p_q} <= 3'h7;
      {rdy_m_q, rdy_s_q, slp_m_q, slp_s_q} <= 4'h0;
    end else begin
      {scl_m_q, scl_s_q, scl_p_q} <= {scl_in, scl_m_q, scl_s_q};
      {sda_m_q, sda_s_q, sda_p_q} <= {sda_in, sda_m_q, sda_s_q};
      {rdy_m_q, rdy_s_q} <= {periph_clk_ready, rdy_m_q};
      {slp_m_q, slp_s_q} <= {sleep_active, slp_m_q};
    end
  end

  // Bus events seen from the second stage onward only
  logic start_ev, stop_ev, scl_rise, scl_fall;
  assign start_ev = scl_s_q && scl_p_q && sda_p_q && !sda_s_q;
  assign stop_ev = scl_s_q && scl_p_q && !sda_p_q && sda_s_q;
  assign scl_rise = scl_s_q && !scl_p_q;
  assign scl_fall = !scl_s_q && scl_p_q;

  // ****************************************************
  // Registers
  // ****************************************************
  logic [31:0] mode_q, mode_d, match_q, match_d;
  logic [twi_wake_pkg::IRQ_BITS-1:0] stat_q, stat_d, mask_q, mask_d, ev;
  logic [31:0] rdata_d;
  twi_wake_pkg::match_cfg_t cfg;

  // Field unpacking into the config carrier
  always_comb begin
    cfg.partial_wake_enable = mode_q[twi_wake_pkg::PARTIAL_WAKE_EN_BIT];
    cfg.primary_addr = mode_q[twi_wake_pkg::PRIMARY_ADDR_LSB +: 7];
    cfg.extra_addr_enable = {mode_q[twi_wake_pkg::EXTRA_ADDR_3_EN_BIT],
                             mode_q[twi_wake_pkg::EXTRA_ADDR_2_EN_BIT],
                             mode_q[twi_wake_pkg::EXTRA_ADDR_1_EN_BIT]};
    cfg.extra_addr_1 = match_q[twi_wake_pkg::EXTRA_ADDR_1_LSB +: 7];
    cfg.extra_addr_2 = match_q[twi_wake_pkg::EXTRA_ADDR_2_LSB +: 7];
    cfg.extra_addr_3 = match_q[twi_wake_pkg::EXTRA_ADDR_3_LSB +: 7];
    cfg.first_data_match_enable = mode_q[twi_wake_pkg::FIRST_DATA_MATCH_EN_BIT];
    cfg.first_data_match_value = match_q[twi_wake_pkg::FIRST_DATA_LSB +: 8];
  end

  // Seven-bit address compare over primary and enabled extras
  function automatic logic addr_hit(input logic [6:0] a, input twi_wake_pkg::match_cfg_t c);
    addr_hit = (a == c.primary_addr)
            || (c.extra_addr_enable[0] && a == c.extra_addr_1)
            || (c.extra_addr_enable[1] && a == c.extra_addr_2)
            || (c.extra_addr_enable[2] && a == c.extra_addr_3);
  endfunction : addr_hit

  twi_wake_pkg::wake_state_t state_q, state_d;

  // Register writes, sticky status with set winning over write-one-clear, read mux
  always_comb begin
    mode_d = mode_q;
    match_d = match_q;
    mask_d = mask_q;
    stat_d = stat_q;
    rdata_d = 32'h0000_0000;
    if (reg_we) begin
      if (reg_addr == twi_wake_pkg::SLAVE_MODE_REG_OFS) begin
        mode_d = reg_wdata;
      end else if (reg_addr == twi_wake_pkg::SLEEP_MATCH_REG_OFS) begin
        match_d = reg_wdata;
      end else if (reg_addr == twi_wake_pkg::IRQ_STATUS_OFS) begin
        stat_d = stat_q & ~reg_wdata[twi_wake_pkg::IRQ_BITS-1:0];
      end else if (reg_addr == twi_wake_pkg::IRQ_MASK_OFS) begin
        mask_d = reg_wdata[twi_wake_pkg::IRQ_BITS-1:0];
      end
    end
    stat_d = stat_d | ev;
    if (reg_re) begin
      if (reg_addr == twi_wake_pkg::SLAVE_MODE_REG_OFS) begin
        rdata_d = mode_q;
      end else if (reg_addr == twi_wake_pkg::SLEEP_MATCH_REG_OFS) begin
        rdata_d = match_q;
      end else if (reg_addr == twi_wake_pkg::IRQ_STATUS_OFS) begin
        rdata_d = {29'h0, stat_q};
      end else if (reg_addr == twi_wake_pkg::IRQ_MASK_OFS) begin
        rdata_d = {29'h0, mask_q};
      end else if (reg_addr == twi_wake_pkg::STATE_OFS) begin
        rdata_d = {26'h0, periph_clk_req, wake_full, 1'b0, state_q};
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      mode_q <= twi_wake_pkg::SLAVE_MODE_RST;
      match_q <= twi_wake_pkg::SLEEP_MATCH_RST;
      mask_q <= twi_wake_pkg::IRQ_MASK_RST;
      stat_q <= 3'h0;
      reg_rdata <= 32'h0000_0000;
    end else begin
      mode_q <= mode_d;
      match_q <= match_d;
      mask_q <= mask_d;
      stat_q <= stat_d;
      reg_rdata <= rdata_d;
    end
  end

  // Level interrupt while any unmasked status bit stands; relies on software masking
  assign irq = |(stat_q & mask_q);

  // ****************************************************
  // Wakeup sequencer
  // ****************************************************
  logic [7:0] shift_q, shift_d;
  logic [3:0] bits_q, bits_d;
  logic [7:0] setup_q, setup_d;
  logic addr_ok_q, addr_ok_d, req_q, req_d, hold_q, hold_d, ack_q, ack_d, wake_d;
  logic [7:0] shifted;

  assign shifted = {shift_q[6:0], sda_s_q};

  always_comb begin
    state_d = state_q;
    shift_d = shift_q;
    bits_d = bits_q;
    setup_d = setup_q;
    addr_ok_d = addr_ok_q;
    req_d = req_q;
    hold_d = hold_q;
    ack_d = ack_q;
    wake_d = 1'b0;
    ev = '0;
    case (state_q)
      twi_wake_pkg::ST_IDLE: begin
        if (start_ev && cfg.partial_wake_enable && slp_s_q) begin
          req_d = 1'b1;
          hold_d = 1'b1;
          setup_d = 8'h00;
          state_d = twi_wake_pkg::ST_STRETCH;
        end
      end
      twi_wake_pkg::ST_STRETCH: begin
        // Stretch lasts as long as the clock source needs, then a setup margin
        if (rdy_s_q) begin
          if (setup_q == 8'(SETUP_CYC - 1)) begin
            hold_d = 1'b0;
            bits_d = 4'h0;
            state_d = twi_wake_pkg::ST_ADDR;
          end else begin
            setup_d = setup_q + 8'h01;
          end
        end
      end
      twi_wake_pkg::ST_ADDR, twi_wake_pkg::ST_DATA: begin
        if (scl_rise) begin
          shift_d = shifted;
          bits_d = bits_q + 4'h1;
          if (bits_q == 4'(twi_wake_pkg::BYTE_BITS - 1)) begin
            if (state_q == twi_wake_pkg::ST_ADDR) begin
              addr_ok_d = addr_hit(shifted[7:1], cfg);
              if (!addr_hit(shifted[7:1], cfg)) begin
                req_d = 1'b0;
                ev[twi_wake_pkg::RESLEEP_BIT] = 1'b1;
                state_d = twi_wake_pkg::ST_IDLE;
              end else if (!cfg.first_data_match_enable) begin
                wake_d = 1'b1;
                ev[twi_wake_pkg::SLAVE_ACCESS_BIT] = 1'b1;
                state_d = twi_wake_pkg::ST_AWAKE;
              end else begin
                state_d = twi_wake_pkg::ST_ACK;
              end
            end else if (addr_ok_q && shifted == cfg.first_data_match_value) begin
              wake_d = 1'b1;
              ev[twi_wake_pkg::SLAVE_ACCESS_BIT] = 1'b1;
              state_d = twi_wake_pkg::ST_AWAKE;
            end else begin
              req_d = 1'b0;
              ev[twi_wake_pkg::RESLEEP_BIT] = 1'b1;
              state_d = twi_wake_pkg::ST_IDLE;
            end
          end
        end
        if (stop_ev || start_ev) begin
          // A framing break mid-byte is no match: go back to sleep
          req_d = 1'b0;
          ev[twi_wake_pkg::BUS_ABORT_BIT] = 1'b1;
          state_d = twi_wake_pkg::ST_IDLE;
        end
      end
      twi_wake_pkg::ST_ACK: begin
        // Acknowledge the address so the master sends the first data byte
        if (scl_fall) begin
          if (!ack_q) begin
            ack_d = 1'b1;
          end else begin
            ack_d = 1'b0;
            bits_d = 4'h0;
            state_d = twi_wake_pkg::ST_DATA;
          end
        end
      end
      twi_wake_pkg::ST_AWAKE: begin
        // Clock stays requested until the device has left sleep
        if (!slp_s_q) begin
          req_d = 1'b0;
          state_d = twi_wake_pkg::ST_IDLE;
        end
      end
      default: begin
        state_d = twi_wake_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state_q <= twi_wake_pkg::ST_IDLE;
      shift_q <= 8'h00;
      bits_q <= 4'h0;
      setup_q <= 8'h00;
      addr_ok_q <= 1'b0;
      req_q <= 1'b0;
      hold_q <= 1'b0;
      ack_q <= 1'b0;
      wake_full <= 1'b0;
    end else begin
      state_q <= state_d;
      shift_q <= shift_d;
      bits_q <= bits_d;
      setup_q <= setup_d;
      addr_ok_q <= addr_ok_d;
      req_q <= req_d;
      hold_q <= hold_d;
      ack_q <= ack_d;
      wake_full <= wake_d;
    end
  end

  // Open-drain pins: only ever drive low
  assign scl_out = 1'b0;
  assign scl_oe = hold_q;
  assign sda_out = 1'b0;
  assign sda_oe = ack_q;
  assign periph_clk_req = req_q;

  // ****************************************************
  // Assertions
  // ****************************************************
  property p_start_wakes;
    @(posedge clk_sys) disable iff (sys_rst)
      (state_q == twi_wake_pkg::ST_IDLE && start_ev && cfg.partial_wake_enable && slp_s_q)
      |=> (periph_clk_req && scl_oe);
  endproperty
  a_start_wakes: assert property (p_start_wakes) else $error("no wake on start");
  property p_stretch_hold;
    @(posedge clk_sys) disable iff (sys_rst)
      (state_q == twi_wake_pkg::ST_STRETCH && !rdy_s_q) |=> scl_oe;
  endproperty
  a_stretch_hold: assert property (p_stretch_hold) else $error("clock released early");
  property p_release;
    @(posedge clk_sys) disable iff (sys_rst)
      $fell(scl_oe) |-> (state_q == twi_wake_pkg::ST_ADDR && $past(rdy_s_q));
  endproperty
  a_release: assert property (p_release) else $error("bad stretch release");
  property p_wake_flag;
    @(posedge clk_sys) disable iff (sys_rst)
      wake_full |-> (stat_q[twi_wake_pkg::SLAVE_ACCESS_BIT] && state_q == twi_wake_pkg::ST_AWAKE);
  endproperty
  a_wake_flag: assert property (p_wake_flag) else $error("wake without access flag");
  property p_resleep;
    @(posedge clk_sys) disable iff (sys_rst)
      $rose(stat_q[twi_wake_pkg::RESLEEP_BIT]) |-> (!periph_clk_req && !wake_full);
  endproperty
  a_resleep: assert property (p_resleep) else $error("clock kept on mismatch");
  property p_addr_miss;
    @(posedge clk_sys) disable iff (sys_rst)
      (state_q == twi_wake_pkg::ST_ADDR && scl_rise && bits_q == 4'h7
       && !addr_hit(shifted[7:1], cfg)) |=> (state_q == twi_wake_pkg::ST_IDLE && !wake_full);
  endproperty
  a_addr_miss: assert property (p_addr_miss) else $error("woke on wrong address");
  property p_data_match;
    @(posedge clk_sys) disable iff (sys_rst)
      (state_q == twi_wake_pkg::ST_DATA && scl_rise && bits_q == 4'h7)
      |=> (wake_full == (addr_ok_q && shift_q == cfg.first_data_match_value));
  endproperty
  a_data_match: assert property (p_data_match) else $error("data match wrong");
  property p_addr_wake;
    @(posedge clk_sys) disable iff (sys_rst)
      (state_q == twi_wake_pkg::ST_ADDR && scl_rise && bits_q == 4'h7 && !stop_ev && !start_ev
       && addr_hit(shifted[7:1], cfg) && !cfg.first_data_match_enable) |=> wake_full ##1 !wake_full;
  endproperty
  a_addr_wake: assert property (p_addr_wake) else $error("no wake on match");
  c_wake: cover property (@(posedge clk_sys) disable iff (sys_rst) wake_full);
  c_resleep: cover property (@(posedge clk_sys) disable iff (sys_rst)
    $rose(stat_q[twi_wake_pkg::RESLEEP_BIT]));
  c_ack: cover property (@(posedge clk_sys) disable iff (sys_rst) $rose(sda_oe));

endmodule : twi_sleep_wake

// ---- hw/twi_wake_pkg.sv ----
// Package of constants and types for the two-wire sleep wakeup matcher.
// Assumes a single 125 MHz system clock and a plain register port.
package twi_wake_pkg;

  // ****************************************************
  // Register map
  // ****************************************************
  localparam logic [7:0] SLAVE_MODE_REG_OFS = 8'h00;
  localparam logic [7:0] SLEEP_MATCH_REG_OFS = 8'h04;
  localparam logic [7:0] IRQ_STATUS_OFS = 8'h08;
  localparam logic [7:0] IRQ_MASK_OFS = 8'h0c;
  localparam logic [7:0] STATE_OFS = 8'h10;

  // slave_mode_reg fields
  localparam int PRIMARY_ADDR_LSB = 0;
  localparam int PARTIAL_WAKE_EN_BIT = 8;
  localparam int EXTRA_ADDR_1_EN_BIT = 9;
  localparam int EXTRA_ADDR_2_EN_BIT = 10;
  localparam int EXTRA_ADDR_3_EN_BIT = 11;
  localparam int FIRST_DATA_MATCH_EN_BIT = 12;

  // sleep_match_reg fields
  localparam int EXTRA_ADDR_1_LSB = 0;
  localparam int EXTRA_ADDR_2_LSB = 8;
  localparam int EXTRA_ADDR_3_LSB = 16;
  localparam int FIRST_DATA_LSB = 24;

  // Status and mask bits
  localparam int SLAVE_ACCESS_BIT = 0;
  localparam int RESLEEP_BIT = 1;
  localparam int BUS_ABORT_BIT = 2;
  localparam int IRQ_BITS = 3;

  // Reset values
  localparam logic [31:0] SLAVE_MODE_RST = 32'h0000_0000;
  localparam logic [31:0] SLEEP_MATCH_RST = 32'h0000_0000;
  localparam logic [IRQ_BITS-1:0] IRQ_MASK_RST = 3'h0;

  // ****************************************************
  // Timing
  // ****************************************************
  localparam int CLK_PERIOD_NS = 8;
  localparam int STRETCH_SETUP_NS = 250;
  // Least time: round up
  localparam int STRETCH_SETUP_CYC = (STRETCH_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BYTE_BITS = 8;

  // ****************************************************
  // Types
  // ****************************************************
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_STRETCH = 3'h1,
    ST_ADDR = 3'h2,
    ST_ACK = 3'h3,
    ST_DATA = 3'h4,
    ST_AWAKE = 3'h5
  } wake_state_t;

  typedef struct packed {
    logic partial_wake_enable;
    logic [6:0] primary_addr;
    logic [2:0] extra_addr_enable;
    logic [6:0] extra_addr_1;
    logic [6:0] extra_addr_2;
    logic [6:0] extra_addr_3;
    logic first_data_match_enable;
    logic [7:0] first_data_match_value;
  } match_cfg_t;

endpackage : twi_wake_pkg

// ---- sim/twi_master_model.sv ----
// Two-wire bus master model that addresses the sleeping slave.
// Assumes open-drain pins with pull-ups; the bench calls frame().
`timescale 1ns/1ns
module twi_master_model (
  input wire logic scl_oe,
  input wire logic sda_oe,
  output logic scl_line,
  output logic sda_line
);
  logic scl_low = 1'b0;
  logic sda_low = 1'b0;
  // Wired-AND with pull-ups: a released line reads high
  assign scl_line = ~(scl_low | scl_oe);
  assign sda_line = ~(sda_low | sda_oe);
  // One bit at 125 ns; clock stands high between frames
  task automatic clk_bit(input logic b);
    sda_low = ~b;
    #31 scl_low = 1'b0;
    wait (scl_line === 1'b1);
    #62 scl_low = 1'b1;
    #32;
  endtask : clk_bit
  // Byte MSB first, then an acknowledge slot with data released
  task automatic send(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) clk_bit(b[i]);
    clk_bit(1'b1);
  endtask : send
  // START, address byte, optional data byte, STOP
  task automatic frame(input logic [7:0] a, input logic [7:0] d, input logic dat);
    #62 sda_low = 1'b1;
    #62 scl_low = 1'b1;
    send(a);
    if (dat) send(d);
    sda_low = 1'b1;
    #31 scl_low = 1'b0;
    #62 sda_low = 1'b0;
  endtask : frame
  // START, upper half of the address byte, then a STOP while the byte is open
  task automatic cut(input logic [7:0] a);
    #62 sda_low = 1'b1;
    #62 scl_low = 1'b1;
    for (int i = 7; i >= 4; i--) clk_bit(a[i]);
    sda_low = 1'b1;
    #31 scl_low = 1'b0;
    #62 sda_low = 1'b0;
  endtask : cut
endmodule : twi_master_model

// ---- sim/i2c_slave_sleep_wakeup_matcher_test.sv ----
// Self-checking bench for the sleep wakeup matcher.
// Assumes the master model and a peripheral clock that starts 40 cycles after a request.
`timescale 1ns/1ns
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin failures++; \
  $display("wrong value %s expected %h seen %h", n, e, g); end end
module i2c_slave_sleep_wakeup_matcher_test;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_we = 1'b0;
  logic reg_re = 1'b0;
  logic [31:0] reg_rdata;
  logic scl_line, scl_out, scl_oe, sda_line, sda_out, sda_oe;
  logic sleep_active = 1'b0;
  logic periph_clk_ready = 1'b0;
  logic periph_clk_req, wake_full, irq;
  int failures = 0;
  int checks = 0;
  int wakes = 0;
  int stretch = 0;
  int ready_cnt = 0;
  int acks = 0;
  always #4 clk_sys = ~clk_sys;
  twi_sleep_wake #(.SETUP_CYC(2)) DUT (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re),
    .reg_rdata(reg_rdata), .scl_in(scl_line), .scl_out(scl_out), .scl_oe(scl_oe),
    .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe), .sleep_active(sleep_active),
    .periph_clk_ready(periph_clk_ready), .periph_clk_req(periph_clk_req),
    .wake_full(wake_full), .irq(irq));
  twi_master_model master (.scl_oe(scl_oe), .sda_oe(sda_oe), .scl_line(scl_line),
    .sda_line(sda_line));
  // Peripheral clock starts late, as from a deep sleep; stops with the request
  always @(posedge clk_sys) begin
    if (periph_clk_req !== 1'b1) begin
      ready_cnt <= 0;
      periph_clk_ready <= 1'b0;
    end else if (ready_cnt == 40) periph_clk_ready <= 1'b1;
    else ready_cnt <= ready_cnt + 1;
  end
  // Count wake pulses, cycles of stretch before the clock runs and cycles of acknowledge
  always @(posedge clk_sys) begin
    if (wake_full === 1'b1) wakes <= wakes + 1;
    if (scl_oe === 1'b1 && periph_clk_ready === 1'b0) stretch <= stretch + 1;
    if (sda_oe === 1'b1) acks <= acks + 1;
  end
  // ****************************************************
  // Register port tasks
  // ****************************************************
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_we <= 1'b1;
    @(posedge clk_sys);
    reg_we <= 1'b0;
  endtask : reg_wr
  task automatic reg_chk(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_re <= 1'b1;
    @(posedge clk_sys);
    reg_re <= 1'b0;
    #1 `CHK("reg_rdata", e, reg_rdata)
  endtask : reg_chk
  // One frame while asleep; dat 0 address only, 1 with data byte, 2 cut by a STOP
  task automatic frame(input logic [7:0] a, input logic [7:0] d, input logic [1:0] dat,
                       input logic ok);
    int w0;
    int s0;
    int k0;
    w0 = wakes;
    s0 = stretch;
    k0 = acks;
    @(posedge clk_sys);
    sleep_active <= 1'b1;
    repeat (10) @(posedge clk_sys);
    if (dat == 2'h2) master.cut(a);
    else master.frame(a, d, dat[0]);
    repeat (10) @(posedge clk_sys);
    `CHK("stretch", 1'b1, (stretch - s0) >= 38)
    `CHK("scl_oe", 1'b0, scl_oe)
    `CHK("pin drive", 2'h0, {scl_out, sda_out})
    `CHK("ack", dat == 2'h1 && a == 8'h54, (acks - k0) > 0)
    `CHK("wakes", ok ? 1 : 0, wakes - w0)
    `CHK("periph_clk_req", ok, periph_clk_req)
    `CHK("irq", ok, irq)
    reg_chk(twi_wake_pkg::STATE_OFS, ok ? 32'h25 : 32'h0);
    reg_chk(twi_wake_pkg::IRQ_STATUS_OFS, ok ? 32'h1 : (dat[1] ? 32'h4 : 32'h2));
    reg_wr(twi_wake_pkg::IRQ_STATUS_OFS, 32'h7);
    sleep_active <= 1'b0;
    repeat (5) @(posedge clk_sys);
    `CHK("irq clear", 1'b0, irq)
    `CHK("req drop", 1'b0, periph_clk_req)
  endtask : frame
  task automatic summarize;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : summarize
  // ****************************************************
  // Test sequence
  // ****************************************************
  initial begin
    repeat (5) @(posedge clk_sys);
    sys_rst <= 1'b0;
    reg_chk(twi_wake_pkg::SLAVE_MODE_REG_OFS, twi_wake_pkg::SLAVE_MODE_RST);
    reg_chk(twi_wake_pkg::SLEEP_MATCH_REG_OFS, twi_wake_pkg::SLEEP_MATCH_RST);
    reg_chk(twi_wake_pkg::IRQ_MASK_OFS, 32'h0);
    reg_chk(twi_wake_pkg::IRQ_STATUS_OFS, 32'h0);
    reg_chk(twi_wake_pkg::STATE_OFS, 32'h0);
    reg_chk(8'h40, 32'h0);
    // Only the access flag may interrupt while walking asleep
    reg_wr(twi_wake_pkg::IRQ_MASK_OFS, 32'h1);
    reg_wr(twi_wake_pkg::SLEEP_MATCH_REG_OFS, 32'ha533_2211);
    reg_wr(twi_wake_pkg::SLAVE_MODE_REG_OFS, 32'h0000_012a);
    reg_chk(twi_wake_pkg::SLAVE_MODE_REG_OFS, 32'h0000_012a);
    frame(8'h54, 8'h00, 2'h0, 1'b1);
    frame(8'h55, 8'h00, 2'h0, 1'b1);
    frame(8'h22, 8'h00, 2'h0, 1'b0);
    // A STOP inside the address byte drops the clock request
    frame(8'h54, 8'h00, 2'h2, 1'b0);
    // Each extra address wakes only while its own enable is set
    for (int i = 0; i < 3; i++) begin
      reg_wr(twi_wake_pkg::SLAVE_MODE_REG_OFS, 32'h0000_012a | (32'h200 << i));
      frame({7'(7'h11 * (i + 1)), 1'b0}, 8'h00, 2'h0, 1'b1);
      frame({7'(7'h11 * ((i + 1) % 3 + 1)), 1'b0}, 8'h00, 2'h0, 1'b0);
    end
    // First data byte must match as well
    reg_wr(twi_wake_pkg::SLAVE_MODE_REG_OFS, 32'h0000_112a);
    frame(8'h54, 8'ha5, 2'h1, 1'b1);
    frame(8'h54, 8'h5a, 2'h1, 1'b0);
    frame(8'h22, 8'ha5, 2'h1, 1'b0);
    summarize();
  end
  // Watchdog well past the 13 frames of at most about 3 us each
  initial begin
    #300000;
    failures++;
    summarize();
  end
endmodule : i2c_slave_sleep_wakeup_matcher_test
